//--- canopen_nmt_error_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e, m) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
    $display("MISMATCH t=%0t %s", $time, m); end end
module canopen_nmt_error_control_bench;
    import cnmt_pkg::*;
    localparam logic [6:0]  NODE = 7'h05;
    localparam logic [15:0] CODES [CNMT_NUM_FAULTS] = '{CNMT_FC_MOT_OT, CNMT_FC_PWR_OT,
        CNMT_FC_DC_OV, CNMT_FC_I2T_WARN, CNMT_FC_MOT_WARN, CNMT_FC_DRV_WARN,
        CNMT_FC_SEQ_CMD, CNMT_FC_SEQ_JMP, CNMT_FC_STACK};
    logic                       clk, resetn, rx_valid, tx_ready, tx_valid, od_rvalid;
    logic                       app_load_done, can_init_done, app_load_req, can_init_req;
    logic                       sdo_enable, pdo_enable;
    logic [CNMT_NUM_FAULTS-1:0] fault_evt;
    logic [7:0]                 nmt_state_code;
    logic [31:0]                od_rdata;
    cnmt_frame_s                rx_frame, tx_frame;
    cnmt_od_req_s               od_req;
    int                         n_mismatch, comparisons, cyc;
    ////////////////////////////////////////////////////////////////////////////////
    // Short tick keeps millisecond periods to a few cycles
    cnmt_core #(.TICK_CYC(10)) DUT (.clk(clk), .resetn(resetn), .node_id(NODE),
        .fault_evt(fault_evt), .error_register(8'h3C), .rx_valid(rx_valid),
        .rx_frame(rx_frame), .od_req(od_req), .tx_ready(tx_ready),
        .app_load_done(app_load_done), .can_init_done(can_init_done),
        .tx_valid(tx_valid), .tx_frame(tx_frame), .od_rdata(od_rdata),
        .od_rvalid(od_rvalid), .app_load_req(app_load_req), .can_init_req(can_init_req),
        .sdo_enable(sdo_enable), .pdo_enable(pdo_enable), .nmt_state_code(nmt_state_code));
    cnmt_host host (.clk(clk), .tx_valid(tx_valid), .tx_frame(tx_frame),
        .od_rdata(od_rdata), .od_rvalid(od_rvalid), .rx_valid(rx_valid),
        .rx_frame(rx_frame), .od_req(od_req), .tx_ready(tx_ready));
    // Clock and cycle count
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) cyc++;
    // Loader and controller answer 1 ns after being asked, within the same cycle
    always @(posedge clk) begin
        #1;
        app_load_done = app_load_req;
        can_init_done = can_init_req;
    end
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Bounded wait for the next frame taken from the node
    task automatic wait_frame(output cnmt_frame_s f);
        int n = 0;
        f = '0;
        while (host.q.size() == 0 && n < 300) begin
            @(posedge clk);
            #2;
            n++;
        end
        `CHK(host.q.size() > 0, 1'b1, "no frame")
        if (host.q.size() > 0)
            f = host.q.pop_front();
    endtask
    task automatic chk_frame(input cnmt_frame_s f, input logic [3:0] n, input logic [7:0] b);
        `CHK(f.id, CNMT_HB_BASE + 11'(NODE), "frame identifier")
        `CHK(f.dlc, n, "frame length")
        `CHK(f.data[63:56], b, "frame state byte")
    endtask
    task automatic pulse(input int i);
        @(posedge clk);
        #1;
        fault_evt = 9'h001 << i;
        @(posedge clk);
        #1;
        fault_evt = '0;
    endtask
    task automatic nmt(input logic [7:0] cs, input logic [7:0] nd, input logic [7:0] st);
        host.send_nmt(cs, nd);
        repeat (2) @(posedge clk);
        #2;
        `CHK(nmt_state_code, st, "state code after command")
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_boot();
        cnmt_frame_s f;
        logic [31:0] d;
        wait_frame(f);
        chk_frame(f, 4'h1, CNMT_HB_BOOT);
        host.od_access(1'b1, 1'b0, CNMT_IDX_HBT, CNMT_SUB_COUNT, 32'h0, d);
        `CHK(d[15:0], CNMT_HBT_RESET, "period reset value")
        `CHK({nmt_state_code, sdo_enable, pdo_enable}, {CNMT_HB_PREOP, 2'b10}, "preop")
        host.od_access(1'b1, 1'b0, CNMT_IDX_HIST, CNMT_SUB_COUNT, 32'h0, d);
        `CHK(d[7:0], 8'h00, "empty history")
        $display("test boot done");
    endtask
    // Every fault code with a stalling receiver, then history and clear
    task automatic t_emcy();
        cnmt_frame_s f;
        logic [31:0] d;
        host.slow = 1'b1;
        for (int i = 0; i < CNMT_NUM_FAULTS; i++) begin
            pulse(i);
            wait_frame(f);
            `CHK(f.id, CNMT_EMCY_BASE + 11'(NODE), "emergency identifier")
            `CHK(f.dlc, 4'h8, "emergency length")
            `CHK(f.data, {CODES[i][7:0], CODES[i][15:8], 8'h3C, 40'h0}, "payload")
        end
        host.slow = 1'b0;
        host.od_access(1'b1, 1'b0, CNMT_IDX_HIST, CNMT_SUB_COUNT, 32'h0, d);
        `CHK(d[7:0], 8'h04, "full history count")
        host.od_access(1'b1, 1'b0, CNMT_IDX_HIST, CNMT_SUB_NEWEST, 32'h0, d);
        `CHK(d[15:0], CNMT_FC_STACK, "newest entry")
        host.od_access(1'b1, 1'b0, CNMT_IDX_HIST, CNMT_SUB_SECOND, 32'h0, d);
        `CHK(d[15:0], CNMT_FC_SEQ_JMP, "second entry")
        host.od_access(1'b0, 1'b1, CNMT_IDX_HIST, CNMT_SUB_COUNT, 32'h0, d);
        host.od_access(1'b1, 1'b0, CNMT_IDX_HIST, CNMT_SUB_COUNT, 32'h0, d);
        `CHK(d[7:0], 8'h00, "cleared history")
        $display("test emcy done");
    endtask
    // Commands, foreign node, fault held while stopped, both resets
    task automatic t_nmt();
        cnmt_frame_s f;
        nmt(CNMT_CS_START, 8'h00, CNMT_HB_OPER);
        `CHK({sdo_enable, pdo_enable, host.q.size() == 0}, 3'b111, "operational")
        nmt(CNMT_CS_STOP, 8'h05, CNMT_HB_STOPPED);
        pulse(0);
        repeat (30) @(posedge clk) #2;
        `CHK({sdo_enable, pdo_enable, host.q.size() == 0}, 3'b001, "stopped")
        nmt(CNMT_CS_PREOP, 8'h09, CNMT_HB_STOPPED);
        nmt(CNMT_CS_PREOP, 8'h05, CNMT_HB_PREOP);
        wait_frame(f);
        `CHK(f.data[63:48], {CNMT_FC_MOT_OT[7:0], CNMT_FC_MOT_OT[15:8]}, "held fault")
        nmt(CNMT_CS_RSTAPP, 8'h00, CNMT_HB_BOOT);
        `CHK({sdo_enable, pdo_enable}, 2'b00, "silent in reset")
        wait_frame(f);
        chk_frame(f, 4'h1, CNMT_HB_BOOT);
        nmt(CNMT_CS_RSTCOM, 8'h05, CNMT_HB_BOOT);
        wait_frame(f);
        chk_frame(f, 4'h1, CNMT_HB_BOOT);
        $display("test nmt done");
    endtask
    // Two millisecond period, then period zero silences it
    task automatic t_hb();
        cnmt_frame_s f;
        logic [31:0] d;
        int          t0;
        nmt(CNMT_CS_START, 8'h05, CNMT_HB_OPER);
        host.od_access(1'b0, 1'b1, CNMT_IDX_HBT, CNMT_SUB_COUNT, 32'h2, d);
        wait_frame(f);
        t0 = cyc;
        wait_frame(f);
        chk_frame(f, 4'h1, CNMT_HB_OPER);
        `CHK((cyc - t0) >= 20 && (cyc - t0) <= 21, 1'b1, "heartbeat spacing")
        host.od_access(1'b0, 1'b1, CNMT_IDX_HBT, CNMT_SUB_COUNT, 32'h0, d);
        repeat (3) @(posedge clk) #2;
        host.q.delete();
        repeat (60) @(posedge clk) #2;
        `CHK(host.q.size() == 0, 1'b1, "heartbeat while period zero")
        $display("test hb done");
    endtask
    // Main sequence
    initial begin
        resetn = 1'b0;
        fault_evt = '0;
        app_load_done = 1'b0;
        can_init_done = 1'b0;
        repeat (8) @(posedge clk);
        #1;
        resetn = 1'b1;
        t_boot();
        t_emcy();
        t_nmt();
        t_hb();
        conclude();
    end
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        conclude();
    end
endmodule
`default_nettype wire

//--- cnmt_core.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// R1: Emergency frame on 080h plus node number
// R2: Eight bytes: code, error register, zeros
// R3: Thermal and overvoltage faults use fixed codes
// R4: Warning conditions use their own codes
// R5: Sequence and software faults use codes
// R6: Four-entry shifting history, newest first
// R7: Subindex zero reads stored count
// R8: Writing zero to subindex zero clears history
// R9: Heartbeat on 700h plus node, state byte
// R10: Heartbeat spacing from period in ms
// R11: Bootup frame data zero, then pre-operational
// R12: Bootup counts as first heartbeat
// R13: Two-byte management command on 000h
// R14: Node field zero addresses this node
// R15: No acknowledgement of management commands
// R16: Command codes select target states
// R17: Automatic transitions made by node itself
// R18: Application reset reloads stored parameters
// R19: Communication reset reinitialises controller
// R20: Pre-operational: SDO and NMT, no PDO
// R21: Operational: SDO, PDO and NMT
// R22: Stopped: only heartbeat and NMT
// R23: Ignore foreign nodes; no heartbeat period zero
module cnmt_core
    import cnmt_pkg::*;
#(
    parameter int TICK_CYC = CNMT_TICK_CYC
) (
    input  wire logic                       clk,
    input  wire logic                       resetn,
    input  wire logic [6:0]                 node_id,
    input  wire logic [CNMT_NUM_FAULTS-1:0] fault_evt,
    input  wire logic [7:0]                 error_register,
    input  wire logic                       rx_valid,
    input  wire cnmt_frame_s                rx_frame,
    input  wire cnmt_od_req_s               od_req,
    input  wire logic                       tx_ready,
    input  wire logic                       app_load_done,
    input  wire logic                       can_init_done,
    output logic                            tx_valid,
    output cnmt_frame_s                     tx_frame,
    output logic [31:0]                     od_rdata,
    output logic                            od_rvalid,
    output logic                            app_load_req,
    output logic                            can_init_req,
    output logic                            sdo_enable,
    output logic                            pdo_enable,
    output logic [7:0]                      nmt_state_code
);

    ////////////////////////////////////////////////////////////////////////
    // Fault code table, one entry per event input
    localparam logic [15:0] FAULT_CODE [CNMT_NUM_FAULTS] = '{
        CNMT_FC_MOT_OT, CNMT_FC_PWR_OT, CNMT_FC_DC_OV,          // R3
        CNMT_FC_I2T_WARN, CNMT_FC_MOT_WARN, CNMT_FC_DRV_WARN,   // R4
        CNMT_FC_SEQ_CMD, CNMT_FC_SEQ_JMP, CNMT_FC_STACK         // R5
    };

    cnmt_state_e        state_reg;
    logic [15:0]        hist_reg [CNMT_HIST_DEPTH];
    logic [2:0]         hist_count_reg;
    logic [15:0]        hb_period_reg;
    logic [15:0]        ms_count_reg;
    logic [$clog2(TICK_CYC+1)-1:0] tick_div_reg;
    logic               tick;
    logic [CNMT_NUM_FAULTS-1:0] fault_pend_reg;
    logic               boot_pend_reg;
    logic               hb_due_reg;
    logic               cmd_hit;
    logic               hist_clear;
    logic               tx_done;
    logic [$clog2(CNMT_NUM_FAULTS)-1:0] fault_sel;
    logic               fault_any;
    logic               emcy_fire;

    ////////////////////////////////////////////////////////////////////////
    // Management command decode
    assign cmd_hit = rx_valid && rx_frame.id == CNMT_NMT_ID                       // R13
                   && rx_frame.dlc == 4'h2
                   && (rx_frame.data[55:48] == 8'h00                             // R14
                       || rx_frame.data[55:48] == {1'b0, node_id});             // R23
    assign tx_done = tx_valid && tx_ready;

    // Node state machine; commands are never answered
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= CNMT_ST_RSTAPP;
        end else if (cmd_hit && state_reg inside {CNMT_ST_PREOP, CNMT_ST_OPER,
                                                  CNMT_ST_STOPPED}) begin
            unique case (rx_frame.data[63:56])                                    // R16 R15
                CNMT_CS_START:  state_reg <= CNMT_ST_OPER;
                CNMT_CS_STOP:   state_reg <= CNMT_ST_STOPPED;
                CNMT_CS_PREOP:  state_reg <= CNMT_ST_PREOP;
                CNMT_CS_RSTAPP: state_reg <= CNMT_ST_RSTAPP;
                CNMT_CS_RSTCOM: state_reg <= CNMT_ST_RSTCOM;
                default:        state_reg <= state_reg;
            endcase
        end else begin
            unique case (state_reg)                                               // R17
                CNMT_ST_RSTAPP:  if (app_load_done) state_reg <= CNMT_ST_RSTCOM;  // R18
                CNMT_ST_RSTCOM:  if (can_init_done) state_reg <= CNMT_ST_INIT;    // R19
                CNMT_ST_INIT:    if (tx_done && boot_pend_reg) state_reg <= CNMT_ST_PREOP; // R11
                CNMT_ST_PREOP:   state_reg <= state_reg;
                CNMT_ST_OPER:    state_reg <= state_reg;
                CNMT_ST_STOPPED: state_reg <= state_reg;
            endcase
        end
    end

    // Reset-state requests and service permissions, all registered
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            app_load_req   <= 1'b0;
            can_init_req   <= 1'b0;
            sdo_enable     <= 1'b0;
            pdo_enable     <= 1'b0;
            nmt_state_code <= CNMT_HB_BOOT;
        end else begin
            app_load_req   <= state_reg == CNMT_ST_RSTAPP && !app_load_done;     // R18
            can_init_req   <= state_reg == CNMT_ST_RSTCOM && !can_init_done;     // R19
            sdo_enable     <= state_reg inside {CNMT_ST_PREOP, CNMT_ST_OPER};     // R20 R22
            pdo_enable     <= state_reg == CNMT_ST_OPER;                          // R21
            unique case (state_reg)
                CNMT_ST_PREOP:   nmt_state_code <= CNMT_HB_PREOP;
                CNMT_ST_OPER:    nmt_state_code <= CNMT_HB_OPER;
                CNMT_ST_STOPPED: nmt_state_code <= CNMT_HB_STOPPED;
                default:         nmt_state_code <= CNMT_HB_BOOT;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Heartbeat period register, kept across the reset states
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hb_period_reg <= CNMT_HBT_RESET;
        end else if (od_req.wr && od_req.index == CNMT_IDX_HBT
                     && od_req.sub == CNMT_SUB_COUNT) begin
            hb_period_reg <= od_req.wdata[15:0];                                  // R10
        end
    end

    // Millisecond tick divider
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tick_div_reg <= '0;
        end else if (tick) begin
            tick_div_reg <= '0;
        end else begin
            tick_div_reg <= tick_div_reg + 1'b1;
        end
    end
    assign tick = tick_div_reg == ($clog2(TICK_CYC+1))'(TICK_CYC - 1);

    // Heartbeat timer restarts on each heartbeat or bootup sent
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ms_count_reg <= '0;
            hb_due_reg   <= 1'b0;
        end else if (hb_period_reg == 16'h0000
                     || !(state_reg inside {CNMT_ST_PREOP, CNMT_ST_OPER, CNMT_ST_STOPPED})) begin
            ms_count_reg <= '0;                                                   // R23
            hb_due_reg   <= 1'b0;
        end else if (tx_done && tx_frame.id == CNMT_HB_BASE + {4'h0, node_id}) begin
            ms_count_reg <= '0;                                                   // R12
            hb_due_reg   <= 1'b0;
        end else if (tick) begin
            if (ms_count_reg + 16'h0001 >= hb_period_reg) begin
                hb_due_reg   <= 1'b1;                                             // R10
                ms_count_reg <= '0;
            end else begin
                ms_count_reg <= ms_count_reg + 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fault events latch until their emergency frame is loaded into the transmit slot
    always_comb begin
        fault_sel = '0;
        fault_any = 1'b0;
        for (int i = CNMT_NUM_FAULTS - 1; i >= 0; i--) begin
            if (fault_pend_reg[i]) begin
                fault_sel = ($clog2(CNMT_NUM_FAULTS))'(i);
                fault_any = 1'b1;
            end
        end
    end

    // Emergency may go whenever communication is up; stopped blocks it
    assign emcy_fire = fault_any && !tx_valid
                     && state_reg inside {CNMT_ST_PREOP, CNMT_ST_OPER};          // R22

    // Pending set wins over the send clearing it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fault_pend_reg <= '0;
        end else begin
            fault_pend_reg <= (fault_pend_reg
                               & ~(emcy_fire ? CNMT_NUM_FAULTS'(1) << fault_sel : '0))
                              | fault_evt;                                        // R1
        end
    end

    // Bootup pending is armed in communication reset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            boot_pend_reg <= 1'b0;
        end else if (state_reg == CNMT_ST_RSTCOM) begin
            boot_pend_reg <= 1'b1;
        end else if (state_reg == CNMT_ST_INIT && tx_done) begin
            boot_pend_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit slot: one frame held until taken, dropped in the reset states
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_valid <= 1'b0;
            tx_frame <= '0;
        end else if (tx_valid) begin
            if (tx_ready || state_reg inside {CNMT_ST_RSTAPP, CNMT_ST_RSTCOM}) tx_valid <= 1'b0;
        end else if (state_reg == CNMT_ST_INIT && boot_pend_reg) begin
            tx_valid      <= 1'b1;                                                // R11
            tx_frame.id   <= CNMT_HB_BASE + {4'h0, node_id};
            tx_frame.dlc  <= 4'h1;
            tx_frame.data <= {CNMT_HB_BOOT, 56'h0};
        end else if (emcy_fire) begin
            tx_valid      <= 1'b1;
            tx_frame.id   <= CNMT_EMCY_BASE + {4'h0, node_id};                    // R1
            tx_frame.dlc  <= 4'h8;                                                // R2
            tx_frame.data <= {FAULT_CODE[fault_sel][7:0], FAULT_CODE[fault_sel][15:8],
                              error_register, 40'h0};                             // R2
        end else if (hb_due_reg) begin
            tx_valid      <= 1'b1;                                                // R9
            tx_frame.id   <= CNMT_HB_BASE + {4'h0, node_id};
            tx_frame.dlc  <= 4'h1;
            tx_frame.data <= {nmt_state_code, 56'h0};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fault history: shift on each reported fault, clear on zero write
    assign hist_clear = od_req.wr && od_req.index == CNMT_IDX_HIST
                      && od_req.sub == CNMT_SUB_COUNT && od_req.wdata[7:0] == 8'h00;

    // A fault reported in the clear cycle survives as sole entry
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hist_count_reg <= '0;
            for (int i = 0; i < CNMT_HIST_DEPTH; i++) hist_reg[i] <= '0;
        end else if (emcy_fire) begin
            hist_reg[0] <= FAULT_CODE[fault_sel];                                 // R6
            for (int i = 1; i < CNMT_HIST_DEPTH; i++) begin
                hist_reg[i] <= hist_clear ? 16'h0000 : hist_reg[i-1];
            end
            if (hist_clear) hist_count_reg <= 3'h1;
            else if (hist_count_reg < 3'(CNMT_HIST_DEPTH))
                hist_count_reg <= hist_count_reg + 3'h1;
        end else if (hist_clear) begin
            hist_count_reg <= '0;                                                 // R8
            for (int i = 0; i < CNMT_HIST_DEPTH; i++) hist_reg[i] <= '0;
        end
    end

    // Object dictionary reads answer one cycle later
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            od_rdata  <= '0;
            od_rvalid <= 1'b0;
        end else begin
            od_rvalid <= od_req.rd;
            od_rdata  <= '0;
            if (od_req.index == CNMT_IDX_HIST) begin
                if (od_req.sub == CNMT_SUB_COUNT)
                    od_rdata <= {29'h0, hist_count_reg};                          // R7
                else if (od_req.sub >= CNMT_SUB_NEWEST && od_req.sub <= 8'h04)
                    od_rdata <= {16'h0, hist_reg[2'(od_req.sub - 8'h01)]};
            end else if (od_req.index == CNMT_IDX_HBT) begin
                od_rdata <= {16'h0, hb_period_reg};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_boot_sent;
        tx_done && state_reg == CNMT_ST_INIT;
    endsequence

    a_boot_to_preop: assert property (@(posedge clk) disable iff (!resetn)
        s_boot_sent |=> state_reg == CNMT_ST_PREOP)                               // R11
        else $error("bootup not followed by pre-operational");
    a_boot_frame_id: assert property (@(posedge clk) disable iff (!resetn)
        s_boot_sent |-> tx_frame.id == CNMT_HB_BASE + {4'h0, node_id}
                        && tx_frame.data[63:56] == 8'h00)                         // R11
        else $error("bootup frame wrong");
    a_emcy_frame_form: assert property (@(posedge clk) disable iff (!resetn)
        tx_valid && tx_frame.id == CNMT_EMCY_BASE + {4'h0, node_id}
        |-> tx_frame.dlc == 4'h8 && tx_frame.data[39:0] == 40'h0)                 // R2
        else $error("emergency frame layout wrong");
    a_emcy_fires_out: assert property (@(posedge clk) disable iff (!resetn)
        emcy_fire |=> tx_valid && tx_frame.id == CNMT_EMCY_BASE + {4'h0, node_id}) // R1
        else $error("emergency frame not issued");
    a_hist_shift_new: assert property (@(posedge clk) disable iff (!resetn)
        emcy_fire && !hist_clear |=> hist_reg[1] == $past(hist_reg[0]))           // R6
        else $error("history did not shift");
    a_hist_clear_cnt: assert property (@(posedge clk) disable iff (!resetn)
        hist_clear && !emcy_fire |=> hist_count_reg == 3'h0)                      // R8
        else $error("history not cleared");
    a_count_bound: assert property (@(posedge clk) disable iff (!resetn)
        hist_count_reg <= 3'h4)                                                   // R7
        else $error("history count above four");
    a_pdo_only_oper: assert property (@(posedge clk) disable iff (!resetn)
        pdo_enable |-> $past(state_reg) == CNMT_ST_OPER)                          // R21
        else $error("pdo enabled outside operational");
    a_stop_no_sdo: assert property (@(posedge clk) disable iff (!resetn)
        state_reg == CNMT_ST_STOPPED ##1 state_reg == CNMT_ST_STOPPED |-> !sdo_enable) // R22
        else $error("sdo active while stopped");
    a_no_hb_zero: assert property (@(posedge clk) disable iff (!resetn)
        hb_period_reg == 16'h0000 |=> !hb_due_reg)                                // R23
        else $error("heartbeat due with period zero");
    a_foreign_ignored: assert property (@(posedge clk) disable iff (!resetn)
        rx_valid && rx_frame.id == CNMT_NMT_ID && rx_frame.data[55:48] != 8'h00
        && rx_frame.data[55:48] != {1'b0, node_id}
        && state_reg inside {CNMT_ST_PREOP, CNMT_ST_OPER, CNMT_ST_STOPPED}
        |=> $stable(state_reg))                                                   // R23
        else $error("foreign command changed state");
    a_start_cmd_oper: assert property (@(posedge clk) disable iff (!resetn)
        cmd_hit && rx_frame.data[63:56] == CNMT_CS_START
        && state_reg inside {CNMT_ST_PREOP, CNMT_ST_STOPPED}
        |=> state_reg == CNMT_ST_OPER)                                            // R16
        else $error("start command not obeyed");

endmodule
`default_nettype wire

//--- cnmt_host.sv
`timescale 1ns/1ps
`default_nettype none
// Network master model: commands, object access, frame sink
module cnmt_host
    import cnmt_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         tx_valid,
    input  wire cnmt_frame_s  tx_frame,
    input  wire logic [31:0]  od_rdata,
    input  wire logic         od_rvalid,
    output var  logic         rx_valid,
    output var  cnmt_frame_s  rx_frame,
    output var  cnmt_od_req_s od_req,
    output var  logic         tx_ready
);
    cnmt_frame_s q[$];
    logic        slow = 1'b0;
    ////////////////////////////////////////////////////////////////////////////////
    // Quiet bus at time zero
    initial begin
        rx_valid = 1'b0;
        rx_frame = '0;
        od_req   = '0;
        tx_ready = 1'b0;
    end
    // Slow mode refuses every other cycle to stall the transmitter
    always @(posedge clk) begin
        #1;
        tx_ready = !slow || !tx_ready;
    end
    // Every frame taken off the bus joins the queue
    always @(posedge clk) begin
        if (tx_valid && tx_ready) begin
            q.push_back(tx_frame);
        end
    end
    // Command code in byte one, node in byte two; stale fields inverted after
    task automatic send_nmt(input logic [7:0] cs, input logic [7:0] node);
        @(posedge clk);
        #1;
        rx_frame = '{CNMT_NMT_ID, 4'h2, {cs, node, 48'h0}};
        rx_valid = 1'b1;
        @(posedge clk);
        #1;
        rx_valid = 1'b0;
        rx_frame = ~rx_frame;
    endtask
    // One object access; read data taken while its strobe is high, unknown without it
    task automatic od_access(input logic rd, input logic wr, input logic [15:0] idx,
                             input logic [7:0] sub, input logic [31:0] wd,
                             output logic [31:0] rdata);
        @(posedge clk);
        #1;
        od_req = '{rd, wr, idx, sub, wd};
        @(posedge clk);
        #1;
        od_req = '{1'b0, 1'b0, ~idx, ~sub, ~wd};
        repeat (4) begin
            if (od_rvalid)
                break;
            @(posedge clk);
            #1;
        end
        rdata = od_rvalid ? od_rdata : 32'hX;
    endtask
endmodule
`default_nettype wire

//--- cnmt_pkg.sv
package cnmt_pkg;
    // CAN identifier bases
    localparam logic [10:0] CNMT_EMCY_BASE  = 11'h080;
    localparam logic [10:0] CNMT_HB_BASE    = 11'h700;
    localparam logic [10:0] CNMT_NMT_ID     = 11'h000;
    // Object dictionary indexes and subindexes
    localparam logic [15:0] CNMT_IDX_HIST   = 16'h1003;
    localparam logic [15:0] CNMT_IDX_HBT    = 16'h1017;
    localparam logic [7:0]  CNMT_SUB_COUNT  = 8'h00;
    localparam logic [7:0]  CNMT_SUB_NEWEST = 8'h01;
    localparam logic [7:0]  CNMT_SUB_SECOND = 8'h02;
    localparam logic [15:0] CNMT_HBT_RESET  = 16'h0000;
    localparam int          CNMT_HIST_DEPTH = 4;
    // Management command codes
    localparam logic [7:0]  CNMT_CS_START   = 8'h01;
    localparam logic [7:0]  CNMT_CS_STOP    = 8'h02;
    localparam logic [7:0]  CNMT_CS_PREOP   = 8'h80;
    localparam logic [7:0]  CNMT_CS_RSTAPP  = 8'h81;
    localparam logic [7:0]  CNMT_CS_RSTCOM  = 8'h82;
    // Heartbeat state byte encodings
    localparam logic [7:0]  CNMT_HB_BOOT    = 8'h00;
    localparam logic [7:0]  CNMT_HB_STOPPED = 8'h04;
    localparam logic [7:0]  CNMT_HB_OPER    = 8'h05;
    localparam logic [7:0]  CNMT_HB_PREOP   = 8'h7F;
    // Fault event codes
    localparam logic [15:0] CNMT_FC_MOT_OT   = 16'h4310;
    localparam logic [15:0] CNMT_FC_PWR_OT   = 16'h4210;
    localparam logic [15:0] CNMT_FC_DC_OV    = 16'h3210;
    localparam logic [15:0] CNMT_FC_I2T_WARN = 16'h2380;
    localparam logic [15:0] CNMT_FC_MOT_WARN = 16'h4380;
    localparam logic [15:0] CNMT_FC_DRV_WARN = 16'h4280;
    localparam logic [15:0] CNMT_FC_SEQ_CMD  = 16'h6193;
    localparam logic [15:0] CNMT_FC_SEQ_JMP  = 16'h6192;
    localparam logic [15:0] CNMT_FC_STACK    = 16'h6180;
    localparam int          CNMT_NUM_FAULTS  = 9;
    // Timing: 1 ms tick at 10 MHz
    localparam int          CNMT_CLK_HZ      = 10000000;
    localparam int          CNMT_TICK_US     = 1000;
    localparam int          CNMT_TICK_CYC    = CNMT_CLK_HZ / 1000000 * CNMT_TICK_US;
    localparam int          CNMT_RESET_CYC   = 4;

    typedef enum {
        CNMT_ST_RSTAPP,
        CNMT_ST_RSTCOM,
        CNMT_ST_INIT,
        CNMT_ST_PREOP,
        CNMT_ST_OPER,
        CNMT_ST_STOPPED
    } cnmt_state_e;

    // One CAN frame, transmit or receive
    typedef struct packed {
        logic [10:0] id;
        logic [3:0]  dlc;
        logic [63:0] data;
    } cnmt_frame_s;

    // Object dictionary access
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] index;
        logic [7:0]  sub;
        logic [31:0] wdata;
    } cnmt_od_req_s;
endpackage
